// >>> hdl/flash_ctl_pkg.sv
package flash_ctl_pkg;

	// special-function register addresses
	localparam logic [7:0] addr_program_store_control = 8'h8F;
	localparam logic [7:0] addr_external_ram_page_control = 8'hAA;
	localparam logic [7:0] addr_flash_timing_control = 8'hB6;
	localparam logic [7:0] addr_flash_key_lock = 8'hB7;

	// reset values
	localparam logic [7:0] reset_program_store_control = 8'h00;
	localparam logic [7:0] reset_external_ram_page_control = 8'h00;
	localparam logic [7:0] reset_flash_timing_control = 8'h80;

	// field positions
	localparam int store_write_enable_bit = 0;
	localparam int store_erase_enable_bit = 1;
	localparam int read_oneshot_enable_bit = 7;

	// key codes
	localparam logic [7:0] key_code_first = 8'hA5;
	localparam logic [7:0] key_code_second = 8'hF1;

	// memory geometry
	localparam int external_ram_bytes = 1024;
	localparam int external_ram_addr_bits = 10;
	localparam int flash_page_bytes = 512;
	localparam int flash_page_bits = 9;
	localparam logic [7:0] erased_byte = 8'hFF;

	// lock states as read back in bits 1-0
	typedef enum logic [1:0] {
		key_locked = 2'b00,
		key_first_ok = 2'b01,
		key_unlocked = 2'b10,
		key_disabled = 2'b11
	} key_state_type;

	// register bus access from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_access_type;

	// external-move access from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic short_addr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} xmove_access_type;

	// request to the flash array
	typedef struct packed {
		logic write;
		logic erase;
		logic [15:0] addr;
		logic [7:0] data;
	} flash_request_type;

endpackage : flash_ctl_pkg

// >>> hdl/flash_write_erase_control.sv
`timescale 1ns/100ps
module flash_write_erase_control
	import flash_ctl_pkg::*;
#(
	parameter int ram_bytes = external_ram_bytes
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register access
	input wire sfr_access_type sfr,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	// external-move access
	input wire xmove_access_type xmove,
	output logic [7:0] xmove_rdata,
	// flash array
	output flash_request_type flash_req,
	input wire logic flash_busy,
	output logic flash_sense_full_cycle,
	output logic flash_write_error,
	// interrupts
	input wire logic irq_request,
	output logic irq_hold
);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic sfr_write(input sfr_access_type a, input logic [7:0] addr);
		return a.wr && (a.addr == addr);
	endfunction : sfr_write

	// erase works on whole pages, so the request carries the page's first byte
	function automatic logic [15:0] page_base(input logic [15:0] addr);
		return addr & ~16'(flash_page_bytes - 1);
	endfunction : page_base

	function automatic logic sfr_mapped(input logic [7:0] addr);
		return addr inside {addr_program_store_control, addr_external_ram_page_control,
			addr_flash_timing_control, addr_flash_key_lock};
	endfunction : sfr_mapped

	logic store_write_enable;
	logic store_erase_enable;
	logic [1:0] external_ram_page_select;
	logic read_oneshot_enable;
	key_state_type key_state;
	key_state_type next_key_state;
	logic [7:0] external_ram [0:ram_bytes-1];
	logic [15:0] move_addr;
	logic [external_ram_addr_bits-1:0] ram_index;
	logic flash_access;
	logic flash_grant;
	logic busy_seen;
	logic op_active;
	// decoded strobes
	logic control_write;
	logic page_write;
	logic timing_write;
	logic key_write;
	logic ram_write;
	// flash request fields
	logic write_pulse;
	logic erase_pulse;
	logic [15:0] flash_addr;
	logic [7:0] flash_data;
	// read views
	logic [7:0] control_view;
	logic [7:0] page_view;
	logic [7:0] timing_view;
	logic [7:0] key_view;

	////////////////////////////////////////////////////////////////////////////////
	// access decode

	// one-cycle write strobes, one per register
	assign control_write = sfr_write(sfr, addr_program_store_control);
	assign page_write = sfr_write(sfr, addr_external_ram_page_control);
	assign timing_write = sfr_write(sfr, addr_flash_timing_control);
	assign key_write = sfr_write(sfr, addr_flash_key_lock);
	assign flash_access = xmove.wr && store_write_enable;
	// a locked or disabled key turns the access into an error, never a request
	assign flash_grant = flash_access && (key_state == key_unlocked);
	// RAM is the default target
	assign ram_write = xmove.wr && !store_write_enable;

	////////////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			store_write_enable <= reset_program_store_control[store_write_enable_bit];
			store_erase_enable <= reset_program_store_control[store_erase_enable_bit];
		end else if (control_write) begin
			// stays set until software clears it
			store_write_enable <= sfr.wdata[store_write_enable_bit];
			store_erase_enable <= sfr.wdata[store_erase_enable_bit];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			external_ram_page_select <= reset_external_ram_page_control[1:0];
		end else if (page_write) begin
			// only the page field is stored; the rest reads zero
			external_ram_page_select <= sfr.wdata[1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			read_oneshot_enable <= reset_flash_timing_control[read_oneshot_enable_bit];
		end else if (timing_write) begin
			// reserved bits are not stored
			read_oneshot_enable <= sfr.wdata[read_oneshot_enable_bit];
		end
	end

	assign flash_sense_full_cycle = !read_oneshot_enable;

	////////////////////////////////////////////////////////////////////////////////
	// key lock

	always_comb begin
		next_key_state = key_state;
		unique case (key_state)
			key_locked: begin
				// a flash move before the keys counts as out of order
				if (key_write) begin
					next_key_state = (sfr.wdata == key_code_first) ? key_first_ok : key_disabled;
				end else if (flash_access) begin
					next_key_state = key_disabled;
				end
			end
			key_first_ok: begin
				if (key_write) begin
					next_key_state = (sfr.wdata == key_code_second) ? key_unlocked : key_disabled;
				end else if (flash_access) begin
					next_key_state = key_disabled;
				end
			end
			key_unlocked: begin
				// any further key write is out of order
				if (key_write) begin
					next_key_state = key_disabled;
				end else if (flash_access) begin
					next_key_state = key_locked;
				end
			end
			key_disabled: begin
				// only a reset leaves this state
				next_key_state = key_disabled;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			key_state <= key_locked;
		end else begin
			key_state <= next_key_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// flash request; the array itself applies erase-to-FF and clear-only write

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			write_pulse <= 1'b0;
			erase_pulse <= 1'b0;
		end else begin
			write_pulse <= flash_grant && !store_erase_enable;
			// erase only with both enables set
			erase_pulse <= flash_grant && store_erase_enable;
		end
	end

	// address and data stand until the next flash access
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flash_addr <= 16'h0000;
			flash_data <= 8'h00;
		end else if (flash_access) begin
			// page erase ignores data and low address bits
			flash_addr <= store_erase_enable ? page_base(xmove.addr) : xmove.addr;
			flash_data <= store_erase_enable ? erased_byte : xmove.wdata;
		end
	end

	// flagged in the locked, half-entered and disabled states alike
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			flash_write_error <= 1'b0;
		end else begin
			flash_write_error <= flash_access && (key_state != key_unlocked);
		end
	end

	assign flash_req = {write_pulse, erase_pulse, flash_addr, flash_data};

	////////////////////////////////////////////////////////////////////////////////
	// interrupt hold while flash is busy

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			busy_seen <= 1'b0;
		end else begin
			busy_seen <= flash_busy;
		end
	end

	// held requests are released to the core's priority logic when the op ends
	// covers the request cycle, the busy time and one cycle after
	assign op_active = write_pulse || erase_pulse || flash_busy || busy_seen;
	assign irq_hold = op_active && irq_request;

	////////////////////////////////////////////////////////////////////////////////
	// external RAM

	// 8-bit operands take the page select as high byte
	assign move_addr = xmove.short_addr ? {6'h00, external_ram_page_select, xmove.addr[7:0]} : xmove.addr;
	// top six bits dropped so the RAM mirrors
	assign ram_index = move_addr[external_ram_addr_bits-1:0];

	always_ff @(posedge clk) begin
		if (ram_write) begin
			external_ram[ram_index] <= xmove.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			xmove_rdata <= 8'h00;
		end else if (xmove.rd) begin
			xmove_rdata <= external_ram[ram_index];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read

	// unused bits read as zero and ignore writes
	assign control_view = {6'h00, store_erase_enable, store_write_enable};
	assign page_view = {6'h00, external_ram_page_select};
	assign timing_view = {read_oneshot_enable, 7'h00};
	assign key_view = {6'h00, key_state};

	// one-cycle answers; an unmapped read answers zero with no hit
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sfr_hit <= 1'b0;
		end else begin
			sfr_hit <= sfr.rd && sfr_mapped(sfr.addr);
		end
	end

	// a read in the cycle of a write returns the old value
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sfr_rdata <= 8'h00;
		end else if (!sfr.rd) begin
			sfr_rdata <= 8'h00;
		end else begin
			unique case (sfr.addr)
				addr_program_store_control: begin
					sfr_rdata <= control_view;
				end
				addr_external_ram_page_control: begin
					sfr_rdata <= page_view;
				end
				addr_flash_timing_control: begin
					sfr_rdata <= timing_view;
				end
				addr_flash_key_lock: begin
					sfr_rdata <= key_view;
				end
				default: begin
					sfr_rdata <= 8'h00;
				end
			endcase
		end
	end

endmodule : flash_write_erase_control

// >>> dv/flash_array_model.sv
`timescale 1ns/100ps
module flash_array_model
	import flash_ctl_pkg::*;
(
	// core side
	input wire logic clk,
	input wire logic reset_n,
	input wire flash_request_type flash_req,
	output logic flash_busy
);
	logic [2:0] left;
	// programming kept short so the bench stays quick
	always_ff @(posedge clk) begin
		if (!reset_n)
			left <= 3'h0;
		else if (flash_req.write || flash_req.erase)
			left <= 3'h4;
		else if (left != 3'h0)
			left <= left - 3'h1;
	end
	assign flash_busy = (left != 3'h0);
endmodule : flash_array_model

// >>> dv/flash_ctl_sva.sv
`timescale 1ns/100ps
module flash_ctl_sva
	import flash_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire sfr_access_type sfr,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire flash_request_type flash_req,
	input wire logic flash_busy,
	input wire logic flash_sense_full_cycle,
	input wire logic flash_write_error,
	input wire logic irq_request,
	input wire logic irq_hold
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic mapped;
	assign mapped = sfr.addr inside {8'h8F, 8'hAA, 8'hB6, 8'hB7};
	map_hit_a: assert property (sfr.rd && mapped |=> sfr_hit)
		else $error("mapped read without hit");
	unmapped_quiet_a: assert property (sfr.rd && !mapped |=> !sfr_hit && sfr_rdata == 8'h00)
		else $error("unmapped read answered");
	lock_field_a: assert property (sfr.rd && sfr.addr == 8'hB7 |=> sfr_rdata[7:2] == 6'h00)
		else $error("lock read upper bits set");
	erase_fill_a: assert property (flash_req.erase |-> flash_req.data == 8'hFF)
		else $error("erase data not all ones");
	erase_page_a: assert property (flash_req.erase |-> flash_req.addr[8:0] == 9'h000)
		else $error("erase address not page aligned");
	one_kind_a: assert property (!(flash_req.erase && flash_req.write))
		else $error("write and erase together");
	single_op_a: assert property (flash_req.write |=> !flash_req.write)
		else $error("second write without new keys");
	oneshot_a: assert property (sfr.wr && sfr.addr == 8'hB6
		|=> flash_sense_full_cycle == !$past(sfr.wdata[7])) else $error("sense mode wrong");
	irq_held_a: assert property (irq_request && flash_busy |-> irq_hold)
		else $error("request not held while busy");
	error_blocks_a: assert property (flash_write_error |-> !(flash_req.write || flash_req.erase))
		else $error("flash op despite error");
endmodule : flash_ctl_sva
bind flash_write_erase_control flash_ctl_sva u_flash_ctl_sva (.clk(clk), .reset_n(reset_n),
	.sfr(sfr), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .flash_req(flash_req),
	.flash_busy(flash_busy), .flash_sense_full_cycle(flash_sense_full_cycle),
	.flash_write_error(flash_write_error), .irq_request(irq_request), .irq_hold(irq_hold));

// >>> dv/testbench.sv
`timescale 1ns/100ps
module testbench
	import flash_ctl_pkg::*;
;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	sfr_access_type sfr = '0;
	xmove_access_type xmove = '0;
	logic irq_request = 1'b0;
	logic [7:0] sfr_rdata, xmove_rdata;
	logic sfr_hit, flash_busy, flash_sense_full_cycle, flash_write_error, irq_hold;
	flash_request_type flash_req;
	int err_count = 0;
	int n_checks = 0;
	// one clock stands for the internal oscillator through every flash operation
	always #12.5 clk = ~clk;
	flash_write_erase_control u_flash_write_erase_control (.clk(clk), .reset_n(reset_n),
		.sfr(sfr), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .xmove(xmove),
		.xmove_rdata(xmove_rdata), .flash_req(flash_req), .flash_busy(flash_busy),
		.flash_sense_full_cycle(flash_sense_full_cycle), .flash_write_error(flash_write_error),
		.irq_request(irq_request), .irq_hold(irq_hold));
	flash_array_model u_flash_array_model (.clk(clk), .reset_n(reset_n), .flash_req(flash_req),
		.flash_busy(flash_busy));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	// one-cycle strobe; answers are registered, so sample just after the taking edge
	task automatic sfr_op(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) sfr <= '{wr, !wr, a, d};
		@(posedge clk) sfr <= '0;
		#1;
	endtask : sfr_op
	// flash addresses travel as task arguments, never through external RAM
	task automatic xm_op(input logic wr, input logic sh, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) xmove <= '{wr, !wr, sh, a, d};
		@(posedge clk) xmove <= '0;
		#1;
	endtask : xm_op
	task automatic unlock(input logic [7:0] ctl);
		sfr_op(1'b1, 8'h8F, ctl);
		sfr_op(1'b1, 8'hB7, 8'hA5);
		sfr_op(1'b0, 8'hB7, 8'h00);
		check(sfr_rdata, 8'h01);
		sfr_op(1'b1, 8'hB7, 8'hF1);
		sfr_op(1'b0, 8'hB7, 8'h00);
		check(sfr_rdata, 8'h02);
	endtask : unlock
	////////////////////////////////////////////////////////////////
	task automatic t_reset_values;
		logic [7:0] a[4] = '{8'h8F, 8'hAA, 8'hB6, 8'hB7};
		logic [7:0] e[4] = '{8'h00, 8'h00, 8'h80, 8'h00};
		for (int i = 0; i < 4; i++) begin
			sfr_op(1'b0, a[i], 8'h00);
			check(sfr_rdata, e[i]);
			check({7'h00, sfr_hit}, 8'h01);
		end
		sfr_op(1'b0, 8'h55, 8'h00);
		check({7'h00, sfr_hit}, 8'h00);
		check({7'h00, flash_sense_full_cycle}, 8'h00);
	endtask : t_reset_values
	task automatic t_ram;
		xm_op(1'b1, 1'b0, 16'h0403, 8'h5A);
		xm_op(1'b0, 1'b0, 16'hFC03, 8'h00);
		check(xmove_rdata, 8'h5A);
		sfr_op(1'b1, 8'hAA, 8'h02);
		xm_op(1'b1, 1'b1, 16'h0007, 8'h3C);
		xm_op(1'b0, 1'b0, 16'h0207, 8'h00);
		check(xmove_rdata, 8'h3C);
	endtask : t_ram
	task automatic t_erase;
		// core interrupts stay disabled here, so a request can only wait
		@(posedge clk) irq_request <= 1'b1;
		unlock(8'hFF);
		sfr_op(1'b0, 8'h8F, 8'h00);
		check(sfr_rdata, 8'h03);
		xm_op(1'b1, 1'b0, 16'h0403, 8'h00);
		check({6'h00, flash_req.erase, flash_req.write}, 8'h02);
		check(flash_req.data, 8'hFF);
		check(flash_req.addr[15:8], 8'h04);
		check(flash_req.addr[7:0], 8'h00);
		check({7'h00, irq_hold}, 8'h01);
		xm_op(1'b0, 1'b0, 16'h0003, 8'h00);
		check(xmove_rdata, 8'h5A);
		sfr_op(1'b0, 8'hB7, 8'h00);
		check(sfr_rdata, 8'h00);
		repeat (4) @(posedge clk);
		#1;
		check({7'h00, irq_hold}, 8'h00);
		@(posedge clk) irq_request <= 1'b0;
	endtask : t_erase
	// leaves the lock disabled, so it runs last
	task automatic t_write_then_lockout;
		unlock(8'h01);
		xm_op(1'b1, 1'b0, 16'h0123, 8'h12);
		check({6'h00, flash_req.erase, flash_req.write}, 8'h01);
		check(flash_req.data, 8'h12);
		check(flash_req.addr[15:8], 8'h01);
		check(flash_req.addr[7:0], 8'h23);
		sfr_op(1'b1, 8'hB6, 8'h00);
		check({7'h00, flash_sense_full_cycle}, 8'h01);
		xm_op(1'b1, 1'b0, 16'h0100, 8'h00);
		check({7'h00, flash_write_error}, 8'h01);
		sfr_op(1'b1, 8'hB7, 8'hA5);
		sfr_op(1'b0, 8'hB7, 8'h00);
		check(sfr_rdata, 8'h03);
	endtask : t_write_then_lockout
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		t_reset_values();
		t_ram();
		t_erase();
		t_write_then_lockout();
		tally_and_finish();
	end
endmodule : testbench
